// file: rtl/thermistor_charge_limit_regs.sv
`timescale 1ns/1ps
`include "thermistor_cfg.svh"
// =====================================================
// thermistor limit and charge reduction registers, axi4-lite slave
module thermistor_charge_limit_regs
#(
	parameter logic [7:0] PART_CODE = 8'hA5 // arbitrary value
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] meas_code,
	input wire logic meas_valid,
	input wire logic [15:0] nominal_vreg_mv,
	input wire logic [15:0] nominal_fast_charge_current,
	output logic [2:0] zone_code,
	output logic [15:0] target_vreg_mv,
	output logic [15:0] target_fast_charge_current
);
	// =====================================================
	// storage
	logic [7:0] ctrl_q;
	logic [7:0] cold_q;
	logic [7:0] cool_q;
	logic [7:0] warm_q;
	logic [7:0] hot_q;
	logic [7:0] meas_q;
	logic [31:0] awaddr_q;
	logic aw_held_q;
	logic [7:0] wdata_q;
	logic wstrb0_q;
	logic w_held_q;
	thermistor_pkg::zone_t zone_d;
	logic [2:0] vred;
	logic [2:0] ired;
	logic [19:0] scaled_fast_charge_current;
	logic [3:0] keep_eighths;
	logic do_write;
	logic [7:0] widx;
	logic [7:0] ridx;
	// per register write strobes
	logic wr_ctrl;
	logic wr_cold;
	logic wr_cool;
	logic wr_warm;
	logic wr_hot;
	// decoded bus answers
	logic w_mapped;
	logic [31:0] rdata_d;
	logic [1:0] rresp_d;
	// next charge targets
	logic [15:0] vreg_d;
	logic [15:0] fast_charge_current_d;
	logic [15:0] vreg_cut;

	// =====================================================
	// write channel
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready = !w_held_q && !s_axi_bvalid;
	assign do_write = aw_held_q && w_held_q;
	assign widx = awaddr_q[`ADDR_LSB +: 8];

	// address channel, held until the write completes
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_q <= 1'b0;
			awaddr_q <= 32'h0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_q <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end
		else if (do_write)
			aw_held_q <= 1'b0;
	end

	// data channel, may come before or after the address
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held_q <= 1'b0;
			wdata_q <= 8'h00;
			wstrb0_q <= 1'b0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_q <= 1'b1;
			wdata_q <= s_axi_wdata[7:0];
			wstrb0_q <= s_axi_wstrb[0];
		end
		else if (do_write)
			w_held_q <= 1'b0;
	end

	// index decode for the write answer
	always_comb
	begin
		case (widx)
			`IDX_CTRL, `IDX_COLD, `IDX_COOL, `IDX_WARM, `IDX_HOT, `IDX_PART,
			`IDX_ZONE, `IDX_MEAS:
				w_mapped = 1'b1;
			default:
				w_mapped = 1'b0;
		endcase
	end

	// write response; unmapped index answers slverr
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= w_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// =====================================================
	// write strobes, byte lane 0 only; part code has none
	assign wr_ctrl = do_write && wstrb0_q && (widx == `IDX_CTRL);
	assign wr_cold = do_write && wstrb0_q && (widx == `IDX_COLD);
	assign wr_cool = do_write && wstrb0_q && (widx == `IDX_COOL);
	assign wr_warm = do_write && wstrb0_q && (widx == `IDX_WARM);
	assign wr_hot = do_write && wstrb0_q && (widx == `IDX_HOT);

	// control register, reserved bits stored as written
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_q <= `RST_CTRL;
		end
		else if (wr_ctrl)
		begin
			ctrl_q <= wdata_q;
		end
	end

	// cold limit
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cold_q <= `RST_COLD;
		end
		else if (wr_cold)
		begin
			cold_q <= wdata_q;
		end
	end

	// cool limit
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cool_q <= `RST_COOL;
		end
		else if (wr_cool)
		begin
			cool_q <= wdata_q;
		end
	end

	// warm limit
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			warm_q <= `RST_WARM;
		end
		else if (wr_warm)
		begin
			warm_q <= wdata_q;
		end
	end

	// hot limit
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			hot_q <= `RST_HOT;
		end
		else if (wr_hot)
		begin
			hot_q <= wdata_q;
		end
	end

	// =====================================================
	// read channel, one cycle answer
	assign s_axi_arready = !s_axi_rvalid;
	assign ridx = s_axi_araddr[`ADDR_LSB +: 8];

	// read data decode; unmapped index reads zero with slverr
	always_comb
	begin
		rdata_d = 32'h0;
		rresp_d = `RESP_OKAY;
		case (ridx)
			`IDX_CTRL: rdata_d = {24'h0, ctrl_q};
			`IDX_COLD: rdata_d = {24'h0, cold_q};
			`IDX_COOL: rdata_d = {24'h0, cool_q};
			`IDX_WARM: rdata_d = {24'h0, warm_q};
			`IDX_HOT: rdata_d = {24'h0, hot_q};
			`IDX_PART: rdata_d = {24'h0, PART_CODE};
			`IDX_ZONE: rdata_d = {29'h0, zone_code};
			`IDX_MEAS: rdata_d = {24'h0, meas_q};
			default:
				rresp_d = `RESP_SLVERR;
		endcase
	end

	// read answer, held until taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdata_d;
			s_axi_rresp <= rresp_d;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// =====================================================
	// latest thermistor measurement
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			meas_q <= `RST_MEAS;
		else if (meas_valid)
			meas_q <= meas_code;
	end

	thermistor_zone u_zone
	(
		.meas_code(meas_q),
		.cold_limit(cold_q),
		.cool_limit(cool_q),
		.warm_limit(warm_q),
		.hot_limit(hot_q),
		.zone(zone_d)
	);

	// =====================================================
	// charge targets from zone and reduction codes
	assign vred = ctrl_q[`CTRL_VRED_HI:`CTRL_VRED_LO];
	assign ired = ctrl_q[`CTRL_IRED_HI:`CTRL_IRED_LO];
	assign keep_eighths = `IRED_EIGHTHS - {1'b0, ired};
	assign scaled_fast_charge_current = nominal_fast_charge_current * keep_eighths;
	assign vreg_cut = 16'(vred * `VRED_STEP_MV);

	// voltage cut applies only in the warm zone
	always_comb
	begin
		if (zone_d == thermistor_pkg::zone_warm)
			vreg_d = 16'(nominal_vreg_mv - vreg_cut);
		else
			vreg_d = nominal_vreg_mv;
	end

	// reduced current in cool and warm; zero charge in cold or hot
	always_comb
	begin
		case (zone_d)
			thermistor_pkg::zone_cool, thermistor_pkg::zone_warm:
				fast_charge_current_d = (ired == 3'h0) ? nominal_fast_charge_current : scaled_fast_charge_current[18:3];
			thermistor_pkg::zone_cold, thermistor_pkg::zone_hot:
				fast_charge_current_d = 16'h0;
			default:
				fast_charge_current_d = nominal_fast_charge_current;
		endcase
	end

	// registered zone report
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			zone_code <= 3'h0;
		end
		else
		begin
			zone_code <= zone_d;
		end
	end

	// registered voltage target
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			target_vreg_mv <= 16'h0;
		end
		else
		begin
			target_vreg_mv <= vreg_d;
		end
	end

	// registered current target
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			target_fast_charge_current <= 16'h0;
		end
		else
		begin
			target_fast_charge_current <= fast_charge_current_d;
		end
	end
endmodule

// file: rtl/thermistor_cfg.svh
`ifndef THERMISTOR_CFG_SVH
`define THERMISTOR_CFG_SVH
// =====================================================
// register indices, byte address is four times index
`define IDX_CTRL 8'h61
`define IDX_COLD 8'h62
`define IDX_COOL 8'h63
`define IDX_WARM 8'h64
`define IDX_HOT 8'h65
`define IDX_PART 8'h6F
`define IDX_ZONE 8'h70
`define IDX_MEAS 8'h71
// =====================================================
// reset values
`define RST_CTRL 8'h34
`define RST_COLD 8'h7C
`define RST_COOL 8'h6D
`define RST_WARM 8'h38
`define RST_HOT 8'h27
`define RST_MEAS 8'hFF
// =====================================================
// control register fields
`define CTRL_VRED_HI 6
`define CTRL_VRED_LO 4
`define CTRL_IRED_HI 2
`define CTRL_IRED_LO 0
`define CTRL_MASK 8'h77
`define VRED_STEP_MV 16'd50
`define IRED_EIGHTHS 4'h8
// =====================================================
// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ADDR_LSB 2
`endif

// file: rtl/thermistor_pkg.sv
package thermistor_pkg;
	typedef enum logic [2:0] {zone_cold, zone_cool, zone_normal, zone_warm, zone_hot} zone_t;
endpackage

// file: rtl/thermistor_zone.sv
`timescale 1ns/1ps
`include "thermistor_cfg.svh"
// =====================================================
// zone select from a measurement; an NTC reads higher when colder
module thermistor_zone
(
	input wire logic [7:0] meas_code,
	input wire logic [7:0] cold_limit,
	input wire logic [7:0] cool_limit,
	input wire logic [7:0] warm_limit,
	input wire logic [7:0] hot_limit,
	output thermistor_pkg::zone_t zone
);
	// ordered compare, extremes win
	always_comb
	begin
		if (meas_code >= cold_limit)
			zone = thermistor_pkg::zone_cold;
		else if (meas_code <= hot_limit)
			zone = thermistor_pkg::zone_hot;
		else if (meas_code >= cool_limit)
			zone = thermistor_pkg::zone_cool;
		else if (meas_code <= warm_limit)
			zone = thermistor_pkg::zone_warm;
		else
			zone = thermistor_pkg::zone_normal;
	end
endmodule

// file: testbench/thermistor_regs_props.sv
`timescale 1ns/1ps
`include "thermistor_cfg.svh"
// =====================================================
// bus handshake and zone checks
module thermistor_regs_props
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] meas_code,
	input wire logic meas_valid,
	input wire logic [2:0] zone_code,
	input wire logic [15:0] target_fast_charge_current
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// =====================================================
	// transfer steps
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence b_stall;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	sequence r_stall;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	chk_write_answer: assert property (wr_taken |=> ##1 s_axi_bvalid)
		else $error("write response late");
	chk_bresp_held: assert property (b_stall |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	chk_rdata_held: assert property (r_stall |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_cold_stop: assert property (meas_valid && meas_code == 8'hFF |=> ##1 zone_code == 3'h0 && target_fast_charge_current == 16'h0)
		else $error("coldest code not cold");
endmodule
bind thermistor_charge_limit_regs thermistor_regs_props thermistor_regs_props_i (.*);

// file: testbench/tb_top.sv
`timescale 1ns/1ps
`include "thermistor_cfg.svh"
module tb_top;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, meas_valid = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 0;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
	logic [7:0] meas_code = 0;
	logic [15:0] nominal_vreg_mv = 16'h1068, nominal_fast_charge_current = 16'h0320;
	logic [2:0] zone_code;
	logic [15:0] target_vreg_mv, target_fast_charge_current;
	logic [7:0] ix[6] = '{`IDX_CTRL, `IDX_COLD, `IDX_COOL, `IDX_WARM, `IDX_HOT, `IDX_PART};
	logic [7:0] ex[6] = '{`RST_CTRL, `RST_COLD, `RST_COOL, `RST_WARM, `RST_HOT, 8'h5A};
	logic [7:0] mc[4] = '{8'hFF, 8'h70, 8'h50, 8'h10};
	int zc[4] = '{0, 1, 2, 4};
	int ic[4] = '{0, 100, 800, 0};
	int failures = 0, compares = 0;
	// part code value is arbitrary
	thermistor_charge_limit_regs #(.PART_CODE(8'h5A)) thermistor_charge_limit_regs_i (.*);
	// clock
	always #20 aclk = ~aclk;
	task chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			failures++;
			$display("CHECK FAILED %0t got %h expected %h", $time, s, e);
		end
	endtask
	task test_done;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// bus write, held until each channel is taken
	task wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] st);
		@(posedge aclk);
		s_axi_awaddr <= {22'h0, a, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		@(negedge aclk);
		while (!(s_axi_awready && s_axi_wready)) @(negedge aclk);
		@(posedge aclk);
		s_axi_awvalid <= 0;
		s_axi_wvalid <= 0;
		@(negedge aclk);
		while (!s_axi_bvalid) @(negedge aclk);
		br = s_axi_bresp;
		@(posedge aclk) s_axi_bready <= 0;
	endtask
	// bus read into rd and rr
	task rdr(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= {22'h0, a, 2'h0};
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		@(negedge aclk);
		while (!s_axi_arready) @(negedge aclk);
		@(posedge aclk) s_axi_arvalid <= 0;
		@(negedge aclk);
		while (!s_axi_rvalid) @(negedge aclk);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		@(posedge aclk) s_axi_rready <= 0;
	endtask
	// one measurement, results one edge after the valid is taken
	task meas(input logic [7:0] c);
		@(posedge aclk);
		meas_code <= c;
		meas_valid <= 1;
		@(posedge aclk) meas_valid <= 0;
		@(posedge aclk);
		@(negedge aclk);
	endtask
	// =====================================================
	// main sequence
	initial
	begin
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		for (int i = 0; i < 6; i++)
		begin
			rdr(ix[i]);
			chk(rd, {24'h0, ex[i]});
			wr(ix[i], ~ex[i], 4'hF);
			chk({30'h0, br}, {30'h0, `RESP_OKAY});
			rdr(ix[i]);
			chk(rd, {24'h0, (i == 5) ? ex[i] : ~ex[i]});
		end
		wr(`IDX_COLD, 8'h00, 4'h0);
		rdr(`IDX_COLD);
		chk(rd, {24'h0, ~ex[1]});
		rdr(8'h66);
		chk({30'h0, rr}, {30'h0, `RESP_SLVERR});
		chk(rd, 32'h0);
		wr(8'h66, 8'h00, 4'hF);
		chk({30'h0, br}, {30'h0, `RESP_SLVERR});
		for (int i = 0; i < 5; i++) wr(ix[i], ex[i], 4'hF);
		for (int i = 0; i < 8; i++)
		begin
			wr(`IDX_CTRL, {1'b0, i[2:0], 1'b0, i[2:0]}, 4'hF);
			meas(8'h30);
			chk(zone_code, 32'h3);
			chk(target_vreg_mv, 16'h1068 - 16'(i * 50));
			chk(target_fast_charge_current, 16'(100 * (8 - i)));
		end
		for (int i = 0; i < 4; i++)
		begin
			meas(mc[i]);
			chk(zone_code, zc[i]);
			chk(target_vreg_mv, 16'h1068);
			chk(target_fast_charge_current, ic[i]);
		end
		test_done;
	end
	// watchdog
	initial
	begin
		#100000;
		failures++;
		test_done;
	end
endmodule
